// ==== design/ftr_ahb_front.sv ====
// module: ahb-lite slave front end, one wait state on reads, none on writes
module ftr_ahb_front #(
	parameter int ADDR_W = 16
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [ADDR_W-1:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic hready,
	input wire logic [31:0] rd_data,
	output logic hreadyout,
	output logic [31:0] hrdata,
	output logic hresp,
	output logic rd_take,
	output logic wr_en,
	output logic [ADDR_W-1:0] addr
);

	logic take;
	logic rd_pend_ff;
	logic wr_pend_ff;
	logic [ADDR_W-1:0] addr_ff;
	logic hreadyout_ff;
	logic [31:0] hrdata_ff;

	// address phase accepted on nonseq or seq with hready high
	assign take = hsel & hready & htrans[1];
	assign rd_take = take & ~hwrite;
	assign wr_en = wr_pend_ff; // write strobe lasts the whole data phase
	assign addr = addr_ff;
	assign hreadyout = hreadyout_ff;
	assign hrdata = hrdata_ff;
	assign hresp = ftr_pkg::HRESP_OKAY;

	// latch the address phase
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			addr_ff <= '0;
			rd_pend_ff <= 1'b0;
			wr_pend_ff <= 1'b0;
		end else begin
			if (take) begin
				addr_ff <= haddr;
			end
			rd_pend_ff <= rd_take;
			wr_pend_ff <= take & hwrite & (hsize == ftr_pkg::HSIZE_WORD); // narrow writes dropped
		end
	end

	// read: stall one cycle, then present registered data
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hreadyout_ff <= 1'b1;
			hrdata_ff <= 32'h0000_0000;
		end else begin
			if (rd_take) begin
				hreadyout_ff <= 1'b0;
			end else if (rd_pend_ff) begin
				hreadyout_ff <= 1'b1;
				hrdata_ff <= rd_data;
			end
		end
	end

endmodule : ftr_ahb_front

// ==== design/ftr_pkg.sv ====
// package: register map, field layout and reset values of the telemetry bank
package ftr_pkg;

	// ----------------------------------------------------------------
	// data format
	// ----------------------------------------------------------------
	localparam int DATA_W = 32;
	localparam int FRAC_BITS = 27; // every value is signed, 27 fractional bits
	localparam int NUM_TEL = 8;
	localparam logic [31:0] TEL_RESET = 32'h0000_0000;
	localparam int CLK_HZ = 25_000_000;

	// ----------------------------------------------------------------
	// register indices as printed; byte address is four times the index
	// ----------------------------------------------------------------
	localparam logic [11:0] IDX_SINE = 12'h04ba;
	localparam logic [11:0] IDX_COSINE = 12'h04bc;
	localparam logic [11:0] IDX_ALPHA_CUR = 12'h04d4;
	localparam logic [11:0] IDX_BETA_CUR = 12'h04d6;
	localparam logic [11:0] IDX_ALPHA_VOLT = 12'h04d8;
	localparam logic [11:0] IDX_BETA_VOLT = 12'h04da;
	localparam logic [11:0] IDX_DIRECT_CUR = 12'h04e4;
	localparam logic [11:0] IDX_QUAD_CUR = 12'h04e6;
	localparam logic [11:0] IDX_CTRL = 12'h04f0;
	localparam logic [11:0] IDX_STATUS = 12'h04f2;

	// ----------------------------------------------------------------
	// slot numbers inside the snapshot bank
	// ----------------------------------------------------------------
	localparam int SLOT_SINE = 0;
	localparam int SLOT_COSINE = 1;
	localparam int SLOT_ALPHA_CUR = 2;
	localparam int SLOT_BETA_CUR = 3;
	localparam int SLOT_ALPHA_VOLT = 4;
	localparam int SLOT_BETA_VOLT = 5;
	localparam int SLOT_DIRECT_CUR = 6;
	localparam int SLOT_QUAD_CUR = 7;

	// ----------------------------------------------------------------
	// control and status fields
	// ----------------------------------------------------------------
	localparam int CTRL_FREEZE_BIT = 0; // hold the snapshot while set
	localparam int CTRL_CLEAR_BIT = 1; // write 1: zero the snapshot, self clearing
	localparam logic [1:0] CTRL_RESET = 2'h0;
	localparam int STAT_COUNT_W = 16; // bits 15:0 capture counter
	localparam int STAT_VALID_BIT = 16;
	localparam int STAT_FROZEN_BIT = 17;
	localparam logic [15:0] COUNT_RESET = 16'h0000;

	// ----------------------------------------------------------------
	// bus encodings
	// ----------------------------------------------------------------
	localparam logic [2:0] HSIZE_WORD = 3'h2;
	localparam logic HRESP_OKAY = 1'b0;

endpackage : ftr_pkg

// ==== design/ftr_snap_bank.sv ====
// module: snapshot bank capturing all telemetry words in one edge
module ftr_snap_bank #(
	parameter int NUM = 8,
	parameter int W = 32
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic capture,
	input wire logic clear,
	input wire logic [NUM-1:0][W-1:0] din,
	output logic [NUM-1:0][W-1:0] dout
);

	logic [W-1:0] mem_ff [NUM];

	// every slot is written by the same edge, so a read never sees a mix
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			for (int i = 0; i < NUM; i++) begin
				mem_ff[i] <= ftr_pkg::TEL_RESET;
			end
		end else if (capture) begin
			for (int i = 0; i < NUM; i++) begin
				mem_ff[i] <= din[i];
			end
		end else if (clear) begin
			for (int i = 0; i < NUM; i++) begin
				mem_ff[i] <= ftr_pkg::TEL_RESET;
			end
		end
	end

	// flatten for the reader
	always_comb begin
		for (int i = 0; i < NUM; i++) begin
			dout[i] = mem_ff[i];
		end
	end

endmodule : ftr_snap_bank

// ==== design/ftr_telemetry_regs.sv ====
// module: read-only telemetry register bank of the field-oriented motor controller
//
// Design decision made here: the AHB-Lite register port.
module ftr_telemetry_regs #(
	parameter int ADDR_W = 16
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [ADDR_W-1:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic hready,
	input wire logic [31:0] hwdata,
	output logic hreadyout,
	output logic [31:0] hrdata,
	output logic hresp,
	input wire logic tel_valid,
	input wire logic [31:0] tel_commutation_sine,
	input wire logic [31:0] tel_commutation_cosine,
	input wire logic [31:0] tel_alpha_axis_current,
	input wire logic [31:0] tel_beta_axis_current,
	input wire logic [31:0] tel_alpha_axis_voltage,
	input wire logic [31:0] tel_beta_axis_voltage,
	input wire logic [31:0] tel_direct_axis_current,
	input wire logic [31:0] tel_quadrature_axis_current
);

	// ----------------------------------------------------------------
	// declarations
	// ----------------------------------------------------------------
	logic rd_take;
	logic wr_en;
	logic [ADDR_W-1:0] addr;
	logic [11:0] idx;
	logic [31:0] rd_data;
	logic capture;
	logic clear_req;
	logic freeze_ff;
	logic clear_ff;
	logic valid_ff;
	logic [15:0] count_ff;
	logic [ftr_pkg::NUM_TEL-1:0][31:0] tel_in;
	logic [ftr_pkg::NUM_TEL-1:0][31:0] snap;

	// word index from byte address
	function automatic logic [11:0] word_idx(input logic [ADDR_W-1:0] a);
		logic [ADDR_W-1:0] s;
		s = a >> 2;
		return s[11:0];
	endfunction : word_idx

	// telemetry inputs into bank slot order
	assign tel_in[ftr_pkg::SLOT_SINE] = tel_commutation_sine;
	assign tel_in[ftr_pkg::SLOT_COSINE] = tel_commutation_cosine;
	assign tel_in[ftr_pkg::SLOT_ALPHA_CUR] = tel_alpha_axis_current;
	assign tel_in[ftr_pkg::SLOT_BETA_CUR] = tel_beta_axis_current;
	assign tel_in[ftr_pkg::SLOT_ALPHA_VOLT] = tel_alpha_axis_voltage;
	assign tel_in[ftr_pkg::SLOT_BETA_VOLT] = tel_beta_axis_voltage;
	assign tel_in[ftr_pkg::SLOT_DIRECT_CUR] = tel_direct_axis_current;
	assign tel_in[ftr_pkg::SLOT_QUAD_CUR] = tel_quadrature_axis_current;

	// ----------------------------------------------------------------
	// bus front end
	// ----------------------------------------------------------------
	ftr_ahb_front #(
		.ADDR_W(ADDR_W)
	) u_front (
		.hclk(hclk),
		.hresetn(hresetn),
		.hsel(hsel),
		.haddr(haddr),
		.htrans(htrans),
		.hwrite(hwrite),
		.hsize(hsize),
		.hready(hready),
		.rd_data(rd_data),
		.hreadyout(hreadyout),
		.hrdata(hrdata),
		.hresp(hresp),
		.rd_take(rd_take),
		.wr_en(wr_en),
		.addr(addr)
	);

	assign idx = word_idx(addr);

	// ----------------------------------------------------------------
	// snapshot bank
	// ----------------------------------------------------------------
	// new sample lands only when not frozen; all words in one edge
	assign capture = tel_valid & ~freeze_ff;
	assign clear_req = clear_ff & ~capture;

	ftr_snap_bank #(
		.NUM(ftr_pkg::NUM_TEL),
		.W(ftr_pkg::DATA_W)
	) u_bank (
		.hclk(hclk),
		.hresetn(hresetn),
		.capture(capture),
		.clear(clear_ff),
		.din(tel_in), // raw signed words, no rescaling
		.dout(snap)
	);

	// ----------------------------------------------------------------
	// control register: freeze and clear
	// ----------------------------------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			freeze_ff <= ftr_pkg::CTRL_RESET[ftr_pkg::CTRL_FREEZE_BIT];
			clear_ff <= ftr_pkg::CTRL_RESET[ftr_pkg::CTRL_CLEAR_BIT];
		end else begin
			if (wr_en && idx == ftr_pkg::IDX_CTRL) begin
				freeze_ff <= hwdata[ftr_pkg::CTRL_FREEZE_BIT];
				clear_ff <= hwdata[ftr_pkg::CTRL_CLEAR_BIT];
			end else begin
				clear_ff <= 1'b0; // one-cycle clear pulse
			end
		end
	end

	// status: capture counter and valid flag; capture beats clear
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			count_ff <= ftr_pkg::COUNT_RESET;
			valid_ff <= 1'b0;
		end else begin
			if (capture) begin
				count_ff <= count_ff + 16'h0001;
				valid_ff <= 1'b1;
			end else if (clear_req) begin
				valid_ff <= 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// read mux; writes to telemetry indices are ignored
	// ----------------------------------------------------------------
	always_comb begin
		rd_data = 32'h0000_0000;
		unique case (idx)
			ftr_pkg::IDX_SINE: rd_data = snap[ftr_pkg::SLOT_SINE];
			ftr_pkg::IDX_COSINE: rd_data = snap[ftr_pkg::SLOT_COSINE];
			ftr_pkg::IDX_ALPHA_CUR: rd_data = snap[ftr_pkg::SLOT_ALPHA_CUR];
			ftr_pkg::IDX_BETA_CUR: rd_data = snap[ftr_pkg::SLOT_BETA_CUR];
			ftr_pkg::IDX_ALPHA_VOLT: rd_data = snap[ftr_pkg::SLOT_ALPHA_VOLT];
			ftr_pkg::IDX_BETA_VOLT: rd_data = snap[ftr_pkg::SLOT_BETA_VOLT];
			ftr_pkg::IDX_DIRECT_CUR: rd_data = snap[ftr_pkg::SLOT_DIRECT_CUR];
			ftr_pkg::IDX_QUAD_CUR: rd_data = snap[ftr_pkg::SLOT_QUAD_CUR];
			ftr_pkg::IDX_CTRL: begin
				rd_data[ftr_pkg::CTRL_FREEZE_BIT] = freeze_ff;
			end
			ftr_pkg::IDX_STATUS: begin
				rd_data[ftr_pkg::STAT_COUNT_W-1:0] = count_ff;
				rd_data[ftr_pkg::STAT_VALID_BIT] = valid_ff;
				rd_data[ftr_pkg::STAT_FROZEN_BIT] = freeze_ff;
			end
			default: rd_data = 32'h0000_0000; // unmapped reads as zero
		endcase
	end

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	// address phase of a read to index i, then its stalled cycle
	sequence read_of(logic [11:0] i);
		rd_take && word_idx(haddr) == i ##1 1'b1;
	endsequence

	sequence read_done;
		hreadyout;
	endsequence

	sequence stall_then_ready;
		!hreadyout ##1 hreadyout;
	endsequence

	// cosine read returns the word held when its data phase began
	cosine_read_a: assert property (read_of(ftr_pkg::IDX_COSINE) |=> read_done and
			hrdata == $past(snap[ftr_pkg::SLOT_COSINE]))
		else $error("cosine read returned wrong word");

	// alpha current read returns its snapshot word
	alpha_cur_read_a: assert property (read_of(ftr_pkg::IDX_ALPHA_CUR) |=> read_done and
			hrdata == $past(snap[ftr_pkg::SLOT_ALPHA_CUR]))
		else $error("alpha current read returned wrong word");

	// beta current read returns its snapshot word
	beta_cur_read_a: assert property (read_of(ftr_pkg::IDX_BETA_CUR) |=> read_done and
			hrdata == $past(snap[ftr_pkg::SLOT_BETA_CUR]))
		else $error("beta current read returned wrong word");

	// alpha voltage read returns its snapshot word
	alpha_volt_read_a: assert property (read_of(ftr_pkg::IDX_ALPHA_VOLT) |=> read_done and
			hrdata == $past(snap[ftr_pkg::SLOT_ALPHA_VOLT]))
		else $error("alpha voltage read returned wrong word");

	// beta voltage read returns its snapshot word
	beta_volt_read_a: assert property (read_of(ftr_pkg::IDX_BETA_VOLT) |=> read_done and
			hrdata == $past(snap[ftr_pkg::SLOT_BETA_VOLT]))
		else $error("beta voltage read returned wrong word");

	// direct current read returns its snapshot word
	direct_cur_read_a: assert property (read_of(ftr_pkg::IDX_DIRECT_CUR) |=> read_done and
			hrdata == $past(snap[ftr_pkg::SLOT_DIRECT_CUR]))
		else $error("direct current read returned wrong word");

	// until the first capture the alpha and beta current words read as zero
	currents_zero_a: assert property (!valid_ff |->
			snap[ftr_pkg::SLOT_ALPHA_CUR] == ftr_pkg::TEL_RESET && snap[ftr_pkg::SLOT_BETA_CUR] == ftr_pkg::TEL_RESET)
		else $error("currents not zero before first capture");

	// a bus write alone never moves the voltage words
	volt_write_ignored_a: assert property (wr_en && !capture && !clear_ff |=>
			$stable(snap[ftr_pkg::SLOT_ALPHA_VOLT]) && $stable(snap[ftr_pkg::SLOT_BETA_VOLT]))
		else $error("write changed a voltage register");

	// until the first capture cosine and direct current read as zero
	cos_direct_zero_a: assert property (!valid_ff |->
			snap[ftr_pkg::SLOT_COSINE] == ftr_pkg::TEL_RESET && snap[ftr_pkg::SLOT_DIRECT_CUR] == ftr_pkg::TEL_RESET)
		else $error("cosine or direct current not zero before first capture");

	// sine read returns its snapshot word
	sine_read_a: assert property (read_of(ftr_pkg::IDX_SINE) |=> read_done and
			hrdata == $past(snap[ftr_pkg::SLOT_SINE]))
		else $error("sine read returned wrong word");

	// quadrature current read returns its snapshot word
	quad_read_a: assert property (read_of(ftr_pkg::IDX_QUAD_CUR) |=> read_done and
			hrdata == $past(snap[ftr_pkg::SLOT_QUAD_CUR]))
		else $error("quadrature current read returned wrong word");

	// a captured quadrature current word keeps its sign and magnitude
	signed_kept_a: assert property (capture |=>
			$signed(snap[ftr_pkg::SLOT_QUAD_CUR]) == $signed($past(tel_quadrature_axis_current)))
		else $error("captured value lost its sign");

	// without a capture or clear the whole snapshot stands
	atomic_hold_a: assert property (!capture && !clear_ff |=> $stable(snap))
		else $error("snapshot changed without a capture");

	// a capture takes all eight words in the same edge
	atomic_take_a: assert property (capture |=> snap == $past(tel_in))
		else $error("snapshot not taken whole");

	// a frozen snapshot holds until a clear
	frozen_hold_a: assert property (freeze_ff && !clear_ff |=> $stable(snap))
		else $error("frozen snapshot changed");

	// clear without a capture zeroes every word and drops the valid flag
	clear_zero_a: assert property (clear_ff && !capture |=> snap == '0 && !valid_ff)
		else $error("clear left a word or the valid flag set");

	// the clear bit is a one-cycle pulse unless written again
	clear_pulse_a: assert property (clear_ff && !(wr_en && idx == ftr_pkg::IDX_CTRL) |=> !clear_ff)
		else $error("clear bit did not drop after one cycle");

	// each capture bumps the counter by one and raises the valid flag
	count_step_a: assert property (capture |=> count_ff == $past(count_ff) + 16'h0001 && valid_ff)
		else $error("capture counter or valid flag wrong");

	// a read stalls the bus exactly one cycle
	read_stall_a: assert property (rd_take |=> stall_then_ready)
		else $error("read wait state not exactly one cycle");

	// writes never stall and the response is always okay
	write_nowait_a: assert property (wr_en |-> hreadyout && hresp == ftr_pkg::HRESP_OKAY)
		else $error("write stalled or answered with an error");

	// narrow writes are dropped before they reach any register
	narrow_drop_a: assert property (hsel && hready && htrans[1] && hwrite &&
			hsize != ftr_pkg::HSIZE_WORD |=> !wr_en)
		else $error("narrow write was accepted");

	// the freeze bit follows a word write to the control register
	freeze_write_a: assert property (wr_en && idx == ftr_pkg::IDX_CTRL |=>
			freeze_ff == $past(hwdata[ftr_pkg::CTRL_FREEZE_BIT]))
		else $error("freeze bit did not take the written value");

	// control read shows only the freeze bit
	ctrl_read_a: assert property (read_of(ftr_pkg::IDX_CTRL) |=> read_done and
			hrdata == {31'h0000_0000, $past(freeze_ff)})
		else $error("control read returned wrong word");

	// status read shows frozen, valid and the capture count
	status_read_a: assert property (read_of(ftr_pkg::IDX_STATUS) |=> read_done and
			hrdata == {14'h0000, $past(freeze_ff), $past(valid_ff), $past(count_ff)})
		else $error("status read returned wrong word");

endmodule : ftr_telemetry_regs

// ==== dv/test_ftr_telemetry_regs.sv ====
// testbench: ahb-lite register checks of the read-only telemetry bank
module test_ftr_telemetry_regs;
	timeunit 1ns;
	timeprecision 1ns;

	// ----------------------------------------------------------------
	// signals and tables
	// ----------------------------------------------------------------
	logic hclk;
	logic hresetn;
	logic hsel;
	logic [15:0] haddr;
	logic [1:0] htrans;
	logic hwrite;
	logic [2:0] hsize;
	logic [31:0] hwdata;
	logic hready;
	logic hreadyout;
	logic [31:0] hrdata;
	logic hresp;
	logic tel_valid;
	logic [31:0] tv [8];
	logic [31:0] rd;
	int err_count;
	int compares;
	logic [2:0] xsize;
	// register indices in slot order: sine, cosine, alpha i, beta i, alpha v, beta v, direct i, quad i
	logic [11:0] idx_tab [8] = '{ftr_pkg::IDX_SINE, ftr_pkg::IDX_COSINE, ftr_pkg::IDX_ALPHA_CUR,
		ftr_pkg::IDX_BETA_CUR, ftr_pkg::IDX_ALPHA_VOLT, ftr_pkg::IDX_BETA_VOLT, ftr_pkg::IDX_DIRECT_CUR,
		ftr_pkg::IDX_QUAD_CUR};
	// signed q.27 samples: minus one, plus one, extremes and small values
	logic [31:0] va [8] = '{32'hf800_0000, 32'h0800_0000, 32'h0a00_0000, 32'hf600_0000,
		32'h7fff_ffff, 32'h8000_0000, 32'h0000_0001, 32'hffff_ffff};
	logic [31:0] vb [8] = '{32'h1234_5678, 32'hedcb_a988, 32'h0000_ffff, 32'hffff_0000,
		32'h5a5a_a5a5, 32'ha5a5_5a5a, 32'hfc00_0000, 32'h0400_0000};

	// one slave: its hreadyout is the bus hready
	assign hready = hreadyout;

	ftr_telemetry_regs #(.ADDR_W(16)) i_ftr_telemetry_regs (
		.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(hsize), .hready(hready), .hwdata(hwdata), .hreadyout(hreadyout), .hrdata(hrdata),
		.hresp(hresp), .tel_valid(tel_valid), .tel_commutation_sine(tv[0]), .tel_commutation_cosine(tv[1]),
		.tel_alpha_axis_current(tv[2]), .tel_beta_axis_current(tv[3]), .tel_alpha_axis_voltage(tv[4]),
		.tel_beta_axis_voltage(tv[5]), .tel_direct_axis_current(tv[6]), .tel_quadrature_axis_current(tv[7])
	);

	// ----------------------------------------------------------------
	// clock, watchdog and verdict
	// ----------------------------------------------------------------
	initial begin
		hclk = 1'b0;
		forever #20 hclk = ~hclk;
	end

	// the tests need a few hundred cycles; cut off far beyond that
	initial begin
		#400000;
		err_count++;
		stop_test();
	end

	task stop_test;
		$display("checks %0d errors %0d", compares, err_count);
		if (err_count == 0 && compares > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : stop_test

	// ----------------------------------------------------------------
	// bus tasks
	// ----------------------------------------------------------------
	function automatic logic [15:0] addr_of(input logic [11:0] idx);
		return {2'b00, idx, 2'b00}; // byte address is four times the index
	endfunction : addr_of

	task check(input string what, input logic [31:0] exp, input logic [31:0] got);
		compares++;
		if (got !== exp) begin
			err_count++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask : check

	// hready seen at the falling edge is what the next rising edge samples
	task wait_rdy(output logic [31:0] d, output int w);
		int n;
		n = 0;
		@(negedge hclk);
		while (hready !== 1'b1) begin
			n++;
			if (n > 50) begin
				err_count++;
				stop_test();
			end
			@(negedge hclk);
		end
		d = hrdata;
		w = n;
		@(posedge hclk);
	endtask : wait_rdy

	task ahb_xfer(input logic wr, input logic [15:0] a, input logic [31:0] wd, output logic [31:0] d);
		logic [31:0] dummy;
		int w;
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= a;
		htrans <= 2'b10;
		hwrite <= wr;
		hsize <= xsize;
		wait_rdy(dummy, w);
		htrans <= 2'b00;
		hsel <= 1'b0;
		hwdata <= wd;
		wait_rdy(d, w);
		check("hresp", {31'h0, ftr_pkg::HRESP_OKAY}, {31'h0, hresp});
		// reads stall exactly one cycle, writes none
		check("wait states", wr ? 32'h0000_0000 : 32'h0000_0001, w);
	endtask : ahb_xfer

	task ahb_write(input logic [15:0] a, input logic [31:0] wd);
		logic [31:0] d;
		ahb_xfer(1'b1, a, wd, d);
	endtask : ahb_write

	task ahb_read(input logic [15:0] a, output logic [31:0] d);
		ahb_xfer(1'b0, a, 32'h0000_0000, d);
	endtask : ahb_read

	// read all eight telemetry words; set 0 expects zero, 1 table a, 2 table b
	task check_all(input int set);
		for (int i = 0; i < 8; i++) begin
			ahb_read(addr_of(idx_tab[i]), rd);
			check($sformatf("telemetry slot %0d", i), set == 0 ? 32'h0000_0000 : (set == 1 ? va[i] : vb[i]), rd);
		end
	endtask : check_all

	// present one set of samples with a single tel_valid cycle, then scramble the inputs
	task capture(input int set);
		@(posedge hclk);
		for (int i = 0; i < 8; i++) tv[i] <= set == 1 ? va[i] : vb[i];
		tel_valid <= 1'b1;
		@(posedge hclk);
		tel_valid <= 1'b0;
		for (int i = 0; i < 8; i++) tv[i] <= set == 1 ? ~va[i] : ~vb[i];
	endtask : capture

	task do_reset;
		@(posedge hclk);
		hresetn <= 1'b0;
		repeat (20) @(posedge hclk);
		hresetn <= 1'b1;
	endtask : do_reset

	// ----------------------------------------------------------------
	// test sequence
	// ----------------------------------------------------------------
	initial begin
		err_count = 0;
		compares = 0;
		hresetn = 1'b0;
		hsel = 1'b0;
		haddr = 16'h0000;
		htrans = 2'b00;
		hwrite = 1'b0;
		hsize = 3'h2;
		xsize = ftr_pkg::HSIZE_WORD;
		hwdata = 32'h0000_0000;
		tel_valid = 1'b0;
		for (int i = 0; i < 8; i++) tv[i] = 32'h0000_0000;
		do_reset();
		check_all(0);
		ahb_read(addr_of(ftr_pkg::IDX_STATUS), rd);
		check("status after reset", 32'h0000_0000, rd);
		// signed q.27 words come back unchanged in every slot
		capture(1);
		check_all(1);
		// writes to the read-only words leave them alone
		for (int i = 0; i < 8; i++) ahb_write(addr_of(idx_tab[i]), 32'h0f0f_0f0f);
		check_all(1);
		ahb_read(addr_of(12'h04c0), rd);
		check("unmapped read", 32'h0000_0000, rd);
		// a narrow write to the control register is dropped
		xsize = 3'h0;
		ahb_write(addr_of(ftr_pkg::IDX_CTRL), 32'h0000_0001);
		xsize = ftr_pkg::HSIZE_WORD;
		ahb_read(addr_of(ftr_pkg::IDX_CTRL), rd);
		check("control after narrow write", 32'h0000_0000, rd);
		// frozen snapshot ignores a capture, then takes the whole next one at once
		ahb_write(addr_of(ftr_pkg::IDX_CTRL), 32'h0000_0001);
		capture(2);
		check_all(1);
		ahb_read(addr_of(ftr_pkg::IDX_STATUS), rd);
		check("status frozen", 32'h0003_0001, rd);
		ahb_write(addr_of(ftr_pkg::IDX_CTRL), 32'h0000_0000);
		capture(2);
		check_all(2);
		ahb_read(addr_of(ftr_pkg::IDX_STATUS), rd);
		check("status count", 32'h0001_0002, rd);
		// clear zeroes the snapshot and drops the valid flag
		ahb_write(addr_of(ftr_pkg::IDX_CTRL), 32'h0000_0002);
		check_all(0);
		ahb_read(addr_of(ftr_pkg::IDX_CTRL), rd);
		check("control after clear", 32'h0000_0000, rd);
		ahb_read(addr_of(ftr_pkg::IDX_STATUS), rd);
		check("status valid bit", 32'h0000_0000, rd & 32'h0001_0000);
		// a second reset in mid-run clears captured values again
		capture(1);
		do_reset();
		check_all(0);
		stop_test();
	end

endmodule : test_ftr_telemetry_regs
